// >>> core/spcm_pkg.sv
// Constants, frame layout and CRC helpers for the programming interface.
// Assumes one system clock; control and status bits are plain ports.
package spcm_pkg;
	localparam int SPCM_SPI_PAY = 16;
	localparam int SPCM_SPI_FRM = 20;
	localparam logic [3:0] SPCM_CRC4_PRESET = 4'hF;
	localparam logic [3:0] SPCM_CRC4_POLY = 4'h3;
	localparam logic [2:0] SPCM_CRC3_PRESET = 3'h7;
	localparam logic [2:0] SPCM_CRC3_POLY = 3'h3;
	localparam logic [5:0] SPCM_RD_LEN = 6'h10;
	localparam logic [5:0] SPCM_WR_LEN = 6'h20;
	localparam int SPCM_RD_TGT = 9;
	localparam int SPCM_RD_ADR = 3;
	localparam int SPCM_WR_TGT = 25;
	localparam int SPCM_WR_ADR = 19;
	localparam int SPCM_WR_DAT = 3;
	localparam logic [5:0] SPCM_ACC_ADDR = 6'h3F;
	localparam logic [15:0] SPCM_ACC_DATA = 16'h62D2;
	localparam logic [5:0] SPCM_TX_HALVES = 6'h24;
	localparam int SPCM_CNT_W = 16;
	localparam logic [15:0] SPCM_MIN_HALF = 16'h0002;

	// Whole-word SPI CRC, payload bit 15 first
	function automatic logic [3:0] spcm_crc4(input logic [15:0] w);
		logic [3:0] c;
		logic inv;
		c = SPCM_CRC4_PRESET;
		for (int i = 15; i >= 0; i--) begin
			inv = w[i] ^ c[3];
			c = {c[2:0], 1'b0} ^ (inv ? SPCM_CRC4_POLY : 4'h0);
		end
		return c;
	endfunction

	function automatic logic [2:0] spcm_crc3(input logic [2:0] c,
		input logic b, input logic [2:0] p);
		return {c[1:0], 1'b0} ^ ((b ^ c[2]) ? p : 3'h0);
	endfunction
endpackage

// >>> core/spcm_spi_crc.sv
// SPI frame CRC: appends C3..C0 on MISO and checks the trailing MOSI CRC.
// Assumes an SPI front end on the same clock giving bit strobes and frame
// start and end pulses.
`timescale 1ns/1ps
`default_nettype none
module spcm_spi_crc
	import spcm_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Frame strobes
	input wire logic i_frame_start,
	input wire logic i_frame_end,
	input wire logic i_bit_stb,
	input wire logic i_mosi_bit,
	input wire logic [15:0] i_tx_word,
	input wire logic i_check_en,
	// Results
	output logic o_miso_bit,
	output logic [15:0] o_rx_word,
	output logic o_rx_valid,
	output logic o_crc_err
);
	logic [4:0] cnt_q, cnt_d;
	logic [19:0] rx_q, rx_d;
	logic [15:0] tx_q, tx_d;
	logic [3:0] tcrc_q, tcrc_d;
	logic miso_q, miso_d;
	logic [15:0] word_q, word_d;
	logic val_q, val_d;
	logic err_q, err_d;
	logic [4:0] nxt;
	logic bad;

	always_comb begin
		cnt_d = cnt_q;
		rx_d = rx_q;
		tx_d = tx_q;
		tcrc_d = tcrc_q;
		miso_d = miso_q;
		word_d = word_q;
		val_d = 1'b0;
		err_d = 1'b0;
		nxt = cnt_q + 5'h01;
		bad = spcm_crc4(rx_q[19:4]) != rx_q[3:0];
		if (i_frame_start) begin
			cnt_d = 5'h00;
			tx_d = i_tx_word;
			tcrc_d = spcm_crc4(i_tx_word);
			miso_d = i_tx_word[15];
		end else if (i_bit_stb) begin
			rx_d = {rx_q[18:0], i_mosi_bit};
			if (cnt_q != 5'h1F)
				cnt_d = nxt;
			// Past bit 15 the remainder follows, C3 first
			if (nxt < 5'(SPCM_SPI_PAY))
				miso_d = tx_q[4'(5'd15 - nxt)];
			else if (nxt < 5'(SPCM_SPI_FRM))
				miso_d = tcrc_q[2'(5'd19 - nxt)];
			else
				miso_d = 1'b0;
		end else if (i_frame_end) begin
			if (cnt_q == 5'(SPCM_SPI_PAY)) begin
				word_d = rx_q[15:0];
				val_d = 1'b1;
			end else if (cnt_q == 5'(SPCM_SPI_FRM)) begin
				if (i_check_en && bad) begin
					err_d = 1'b1;
				end else begin
					word_d = rx_q[19:4];
					val_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 5'h00;
			rx_q <= 20'h00000;
			tx_q <= 16'h0000;
			tcrc_q <= 4'h0;
			miso_q <= 1'b0;
			word_q <= 16'h0000;
			val_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			tcrc_q <= tcrc_d;
			miso_q <= miso_d;
			word_q <= word_d;
			val_q <= val_d;
			err_q <= err_d;
		end
	end

	assign o_miso_bit = miso_q;
	assign o_rx_word = word_q;
	assign o_rx_valid = val_q;
	assign o_crc_err = err_q;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	a_crc_discard: assert property (i_frame_end && !i_frame_start &&
		!i_bit_stb && cnt_q == 5'd20 && i_check_en && bad
		|=> o_crc_err && !o_rx_valid)
		else $error("bad SPI CRC frame not discarded");
	a_crc_ignored: assert property (i_frame_end && !i_frame_start &&
		!i_bit_stb && cnt_q == 5'd20 && !i_check_en
		|=> o_rx_valid && !o_crc_err)
		else $error("MOSI CRC not ignored while check is off");
	a_crc_c3_first: assert property (i_bit_stb && !i_frame_start &&
		cnt_q == 5'd15 |=> o_miso_bit == $past(tcrc_q[3]))
		else $error("first CRC bit on MISO is not C3");
endmodule
`default_nettype wire

// >>> core/spcm_top.sv
// Programming interface core: SPI CRC wrapper plus the addressable
// Manchester command receiver on the supply line, answering on PWM.
// Assumes the supply-line comparator, MOSI and chip-select pins arrive
// asynchronously; register access and angle PWM are same-clock logic.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - CRC appended on MISO past 16 bits
// - MOSI CRC ignored unless check enabled
// - Bad CRC drops packet, sets warning
// - SPI CRC x^4+x+1, preset ones, MSB first
// - CRC sent CRC_REMAINDER_BITS
// - Rising mid-bit zero, falling one, MSB first
// - Die identity from MOSI and chip select
// - Manchester disable ignores supply-line input
// - No action before access code
// - Measure rate per frame, answer alike
// - Read answered on open-drain PWM
// - Manchester mode stops angle output at once
// - Exit code restores angle output
// - Device never starts a transaction
// - Two zero sync bits start frame
// - Writes carry 16 data bits, reads none
// - Target bits select matching die identities
// - All-zero target is broadcast
// - Every frame ends in 3-bit CRC
// - Access code opens mode, always broadcast
// - Other data to all-ones address exits
// - Odd address read zeroes upper byte
module spcm_top
	import spcm_pkg::*;
#(
	parameter logic [2:0] CRC3_POLY = SPCM_CRC3_POLY,
	parameter logic [2:0] CRC3_PRESET = SPCM_CRC3_PRESET,
	parameter int CNT_W = SPCM_CNT_W
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Pins
	input wire logic i_vcc_man,
	input wire logic i_mosi_pin,
	input wire logic i_chip_select_n,
	output logic o_pwm_o,
	output logic o_pwm_oe,
	// Configuration
	input wire logic i_manchester_disable,
	input wire logic i_host_crc_check_enable,
	input wire logic i_pwm_output_mode,
	input wire logic i_pwm_angle,
	// SPI frame side
	input wire logic i_spi_frame_start,
	input wire logic i_spi_frame_end,
	input wire logic i_spi_bit_stb,
	input wire logic i_spi_mosi_bit,
	input wire logic [15:0] i_spi_tx_word,
	output logic o_spi_miso_bit,
	output logic [15:0] o_spi_rx_word,
	output logic o_spi_rx_valid,
	input wire logic i_crc_warn_clr,
	output logic o_crc_warn,
	// Register access from Manchester commands
	output logic o_wr_stb,
	output logic [5:0] o_wr_addr,
	output logic [15:0] o_wr_data,
	output logic o_rd_stb,
	output logic [5:0] o_rd_addr,
	input wire logic [15:0] i_rd_data,
	// Status
	output logic o_man_mode,
	output logic [1:0] o_die_id
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_MEAS, ST_RUN, ST_FETCH, ST_TX
	} spcm_st_e;

	logic spi_err;
	logic warn_q, warn_d;

	spcm_spi_crc u_spi_crc (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_frame_start(i_spi_frame_start),
		.i_frame_end(i_spi_frame_end),
		.i_bit_stb(i_spi_bit_stb),
		.i_mosi_bit(i_spi_mosi_bit),
		.i_tx_word(i_spi_tx_word),
		.i_check_en(i_host_crc_check_enable),
		.o_miso_bit(o_spi_miso_bit),
		.o_rx_word(o_spi_rx_word),
		.o_rx_valid(o_spi_rx_valid),
		.o_crc_err(spi_err)
	);

	// New error wins over a clear in the same cycle
	always_comb warn_d = spi_err | (warn_q & ~i_crc_warn_clr);

	// Three-flop pin synchronisers; a change counts once flops 2 and 3 agree
	logic [2:0] vs_q, ms_q, cs_q;
	logic vcc_q, vcc_d;
	logic [1:0] id_q, id_d;

	always_comb begin
		vcc_d = (vs_q[1] == vs_q[2]) ? vs_q[2] : vcc_q;
		id_d[1] = (ms_q[1] == ms_q[2]) ? ms_q[2] : id_q[1];
		id_d[0] = (cs_q[1] == cs_q[2]) ? cs_q[2] : id_q[0];
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			vs_q <= 3'h7;
			ms_q <= 3'h0;
			cs_q <= 3'h0;
			vcc_q <= 1'b1;
			id_q <= 2'h0;
			warn_q <= 1'b0;
		end else begin
			vs_q <= {vs_q[1:0], i_vcc_man};
			ms_q <= {ms_q[1:0], i_mosi_pin};
			cs_q <= {cs_q[1:0], i_chip_select_n};
			vcc_q <= vcc_d;
			id_q <= id_d;
			warn_q <= warn_d;
		end
	end

	// Manchester receiver and responder
	spcm_st_e st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, half_q, half_d;
	logic [5:0] idx_q, idx_d, lenv;
	logic [31:0] sh_q, sh_d, sh_n;
	logic [2:0] crc_q, crc_d;
	logic rd_q, rd_d, mode_q, mode_d, oe_q, oe_d;
	logic wr_q, wr_d, rs_q, rs_d;
	logic [5:0] wa_q, wa_d, ra_q, ra_d, addr;
	logic [15:0] wd_q, wd_d, data;
	logic [17:0] tx_q, tx_d;
	logic [5:0] hn_q, hn_d;
	logic fall, rise, mid, done, ok, hit, drive;
	logic [3:0] tgt;
	logic [CNT_W:0] thr, lim;

	always_comb begin
		st_d = st_q;
		cnt_d = (&cnt_q) ? cnt_q : cnt_q + 1'b1;
		half_d = half_q;
		idx_d = idx_q;
		sh_d = sh_q;
		crc_d = crc_q;
		rd_d = rd_q;
		mode_d = mode_q;
		wr_d = 1'b0;
		wa_d = wa_q;
		wd_d = wd_q;
		rs_d = 1'b0;
		ra_d = ra_q;
		tx_d = tx_q;
		hn_d = hn_q;
		fall = vcc_q & ~vcc_d;
		rise = ~vcc_q & vcc_d;
		thr = {1'b0, half_q} + {2'b00, half_q[CNT_W-1:1]};
		lim = thr + {1'b0, half_q};
		// Edges inside 1.5 half-bits are bit boundaries, later ones mid-bit
		mid = (fall | rise) && {1'b0, cnt_q} >= thr;
		sh_n = {sh_q[30:0], fall};
		lenv = ((idx_q == 6'd2) ? fall : rd_q) ? SPCM_RD_LEN : SPCM_WR_LEN;
		done = 1'b0;
		ok = sh_n[2:0] == crc_q;
		tgt = rd_q ? sh_n[SPCM_RD_TGT +: 4] : sh_n[SPCM_WR_TGT +: 4];
		addr = rd_q ? sh_n[SPCM_RD_ADR +: 6] : sh_n[SPCM_WR_ADR +: 6];
		data = sh_n[SPCM_WR_DAT +: 16];
		// Outside PWM output mode no identity exists, so all is broadcast
		hit = tgt == 4'h0 || !i_pwm_output_mode || tgt[id_q];
		drive = hn_q[0] ? tx_q[17] : ~tx_q[17];
		case (st_q)
			ST_IDLE: begin
				// Only a falling supply edge opens a frame
				if (fall && !i_manchester_disable) begin
					st_d = ST_MEAS;
					cnt_d = '0;
				end
			end
			ST_MEAS: begin
				if (rise) begin
					// First sync half-bit sets this frame's rate
					half_d = cnt_q;
					idx_d = 6'd1;
					sh_d = 32'h0000_0000;
					crc_d = CRC3_PRESET;
					cnt_d = '0;
					st_d = (cnt_q < CNT_W'(SPCM_MIN_HALF)) ? ST_IDLE : ST_RUN;
				end else if (&cnt_q) begin
					st_d = ST_IDLE;
				end
			end
			ST_RUN: begin
				if (mid) begin
					sh_d = sh_n;
					idx_d = idx_q + 6'd1;
					cnt_d = '0;
					if (idx_q == 6'd2)
						rd_d = fall;
					if (idx_q >= 6'd2 && idx_q < lenv - 6'd3)
						crc_d = spcm_crc3(crc_q, fall, CRC3_POLY);
					if (idx_q == 6'd1 && fall)
						st_d = ST_IDLE;
					else if (idx_q + 6'd1 == lenv && idx_q >= 6'd2) begin
						done = 1'b1;
						st_d = ST_IDLE;
					end
				end else if ({1'b0, cnt_q} > lim) begin
					st_d = ST_IDLE;
				end
			end
			ST_FETCH: begin
				tx_d = {2'b00, i_rd_data};
				if (ra_q[0])
					tx_d[15:8] = 8'h00;
				hn_d = 6'd0;
				cnt_d = '0;
				st_d = ST_TX;
			end
			ST_TX: begin
				// Answer uses the half-bit measured on the command
				// Counting 0..half_q gives the host's own half-bit length
				if (cnt_q >= half_q) begin
					cnt_d = '0;
					hn_d = hn_q + 6'd1;
					if (hn_q[0])
						tx_d = {tx_q[16:0], 1'b0};
					if (hn_q + 6'd1 == SPCM_TX_HALVES)
						st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (i_manchester_disable && st_q != ST_TX && st_q != ST_FETCH)
			st_d = ST_IDLE;
		if (done && ok) begin
			if (!rd_q && addr == SPCM_ACC_ADDR) begin
				// Access and exit ignore the target field
				mode_d = data == SPCM_ACC_DATA;
			end else if (mode_q && hit) begin
				if (rd_q) begin
					rs_d = 1'b1;
					ra_d = addr;
					st_d = ST_FETCH;
				end else begin
					wr_d = 1'b1;
					wa_d = addr;
					wd_d = data;
				end
			end
		end
		// Pin follows the angle only outside Manchester mode
		if (mode_d)
			oe_d = st_d == ST_TX && (st_q == ST_TX ? drive : 1'b1);
		else
			oe_d = ~i_pwm_angle;
		if (st_q == ST_TX && st_d == ST_TX && cnt_d == '0)
			oe_d = mode_d && (hn_q[0] ? ~tx_d[17] : tx_q[17]);
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			half_q <= '0;
			idx_q <= 6'd0;
			sh_q <= 32'h0000_0000;
			crc_q <= 3'h0;
			rd_q <= 1'b0;
			mode_q <= 1'b0;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
			wa_q <= 6'h00;
			wd_q <= 16'h0000;
			rs_q <= 1'b0;
			ra_q <= 6'h00;
			tx_q <= 18'h00000;
			hn_q <= 6'd0;
			o_pwm_o <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			half_q <= half_d;
			idx_q <= idx_d;
			sh_q <= sh_d;
			crc_q <= crc_d;
			rd_q <= rd_d;
			mode_q <= mode_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
			wa_q <= wa_d;
			wd_q <= wd_d;
			rs_q <= rs_d;
			ra_q <= ra_d;
			tx_q <= tx_d;
			hn_q <= hn_d;
			o_pwm_o <= 1'b0;
		end
	end

	assign o_pwm_oe = oe_q;
	assign o_man_mode = mode_q;
	assign o_wr_stb = wr_q;
	assign o_wr_addr = wa_q;
	assign o_wr_data = wd_q;
	assign o_rd_stb = rs_q;
	assign o_rd_addr = ra_q;
	assign o_die_id = id_q;
	assign o_crc_warn = warn_q;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_read_taken;
		rs_q && st_q == ST_FETCH;
	endsequence
	sequence s_answer_starts;
		st_q == ST_TX && hn_q == 6'd0 ##1 st_q == ST_TX;
	endsequence

	a_access_opens: assert property (done && ok && !rd_q &&
		addr == SPCM_ACC_ADDR && data == SPCM_ACC_DATA |=> o_man_mode)
		else $error("access code did not open Manchester mode");
	a_exit_closes: assert property (done && ok && !rd_q &&
		addr == SPCM_ACC_ADDR && data != SPCM_ACC_DATA |=> !o_man_mode)
		else $error("exit code did not close Manchester mode");
	a_angle_passes: assert property (!mode_q && !mode_d
		|=> o_pwm_oe == !$past(i_pwm_angle))
		else $error("angle not on pin outside Manchester mode");
	a_angle_stops: assert property (mode_q && mode_d && st_q != ST_TX
		&& st_q != ST_FETCH |=> !o_pwm_oe)
		else $error("pin driven in Manchester mode without an answer");
	a_no_cmd_closed: assert property (!mode_q |=> !o_wr_stb && !o_rd_stb)
		else $error("command acted on before access code");
	a_read_answers: assert property (s_read_taken |=> s_answer_starts)
		else $error("read command not answered on PWM");
	a_tx_from_read: assert property (st_q != ST_TX ##1 st_q == ST_TX
		|-> $past(st_q) == ST_FETCH)
		else $error("answer started without a read");
	a_odd_masked: assert property (st_q == ST_FETCH && ra_q[0]
		|=> tx_q[15:8] == 8'h00)
		else $error("odd read kept its upper byte");
	a_disable_holds: assert property (i_manchester_disable &&
		st_q == ST_IDLE |=> st_q == ST_IDLE)
		else $error("frame started while Manchester disabled");
	a_sync_zero: assert property (st_q == ST_RUN && mid && idx_q == 6'd1
		&& fall |=> st_q == ST_IDLE)
		else $error("non-zero sync bit accepted");
	a_warn_sticky: assert property (spi_err |=> o_crc_warn)
		else $error("CRC warning lost against a clear");
endmodule
`default_nettype wire

// >>> verif/spcm_host_model.sv
// Host controller model: sends Manchester command frames on the supply line.
// Assumes the bench calls send() only after any answer has finished.
`timescale 1ns/1ps
`default_nettype none
module spcm_host_model
	import spcm_pkg::*;
(
	// Clock
	input wire logic i_sys_clk,
	// Supply line, idles high
	output logic o_vcc
);
	import spcm_pkg::*;

	initial begin
		o_vcc = 1'b1;
	end

	// Only the host starts a frame; reads go to one die at a time
	task automatic send(input logic rd, input logic [3:0] tg,
		input logic [5:0] a, input logic [15:0] d, input logic bad,
		input int hb);
		logic [31:0] f;
		logic [2:0] c;
		int p;
		p = rd ? 11 : 27;
		f = rd ? {2'b00, rd, tg, a, 19'h0} : {2'b00, rd, tg, a, d, 3'h0};
		c = SPCM_CRC3_PRESET;
		for (int i = 29; i > 29 - p; i--) begin
			c = {c[1:0], 1'b0} ^ ((f[i] ^ c[2]) ? SPCM_CRC3_POLY : 3'h0);
		end
		// A set bad flag corrupts the check field on purpose
		f[29-p -: 3] = c ^ {2'b00, bad};
		@(posedge i_sys_clk);
		#1;
		for (int i = 31; i > 26 - p; i--) begin
			o_vcc = f[i];
			repeat (hb) @(posedge i_sys_clk);
			#1;
			o_vcc = ~f[i];
			repeat (hb) @(posedge i_sys_clk);
			#1;
		end
		// Idle long enough for the receiver to see the frame end
		o_vcc = 1'b1;
		repeat (4 * hb) @(posedge i_sys_clk);
		#1;
	endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the programming interface core.
// Assumes the host model drives the supply line; SPI strobes come from here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import spcm_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic vcc;
	logic mosi_pin = 1'b1, chip_select_n = 1'b0, man_dis = 1'b0, chk_en = 1'b0;
	logic angle = 1'b1, fs = 1'b0, fe = 1'b0, stb = 1'b0, mbit = 1'b0;
	logic clr = 1'b0, pmode = 1'b1;
	logic [15:0] tx_word = 16'h0000;
	logic pwm_o, pwm_oe, miso, rx_valid, warn, wr_stb, rd_stb, man_mode;
	logic [15:0] rx_word, wr_data, rd_data;
	logic [5:0] wr_addr, rd_addr;
	logic [1:0] die_id;
	int n_fail = 0, checked = 0, n_wr = 0, n_rd = 0, n_rxv = 0;
	int ai = 1024, cyc = 0;
	logic ans [0:1023];

	always #2 i_sys_clk = ~i_sys_clk;
	// Register data never changes mid-read, so every answer is settled
	assign rd_data = {rd_addr, 4'hA, rd_addr};

	spcm_top dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_vcc_man(vcc),
		.i_mosi_pin(mosi_pin), .i_chip_select_n(chip_select_n), .o_pwm_o(pwm_o),
		.o_pwm_oe(pwm_oe), .i_manchester_disable(man_dis),
		.i_host_crc_check_enable(chk_en), .i_pwm_output_mode(pmode),
		.i_pwm_angle(angle), .i_spi_frame_start(fs), .i_spi_frame_end(fe),
		.i_spi_bit_stb(stb), .i_spi_mosi_bit(mbit), .i_spi_tx_word(tx_word),
		.o_spi_miso_bit(miso), .o_spi_rx_word(rx_word),
		.o_spi_rx_valid(rx_valid), .i_crc_warn_clr(clr), .o_crc_warn(warn),
		.o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
		.o_rd_stb(rd_stb), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
		.o_man_mode(man_mode), .o_die_id(die_id));

	spcm_host_model host_u (.i_sys_clk(i_sys_clk), .o_vcc(vcc));

	// Count strobes and record the PWM drive after each read strobe
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (wr_stb === 1'b1)
			n_wr <= n_wr + 1;
		if (rx_valid === 1'b1)
			n_rxv <= n_rxv + 1;
		if (rd_stb === 1'b1) begin
			n_rd <= n_rd + 1;
			ai <= 0;
		end else if (ai < 1024) begin
			ans[ai] <= pwm_oe;
			ai <= ai + 1;
		end
	end

	always @(posedge i_sys_clk) begin
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	function automatic logic [3:0] crc4(input logic [15:0] w);
		logic [3:0] c;
		logic x;
		c = 4'hF;
		for (int i = 15; i >= 0; i--) begin
			x = w[i] ^ c[3];
			c = {c[2:0], x} ^ {2'b00, x, 1'b0};
		end
		return c;
	endfunction

	// One 20-bit frame; bad corrupts the host check bits
	task automatic spi(input logic [15:0] tw, input logic [15:0] mw,
		input logic bad);
		logic [19:0] m, got;
		int r;
		m = {mw, crc4(mw) ^ {3'h0, bad}};
		r = n_rxv;
		tx_word = tw;
		fs = 1'b1;
		tick(1);
		fs = 1'b0;
		for (int i = 19; i >= 0; i--) begin
			tick(1);
			got[i] = miso;
			mbit = m[i];
			stb = 1'b1;
			tick(1);
			stb = 1'b0;
		end
		tick(1);
		fe = 1'b1;
		tick(1);
		fe = 1'b0;
		tick(3);
		chk("miso frame", {tw, crc4(tw)}, got);
		chk("rx valid", (bad && chk_en) ? 0 : 1, n_rxv - r);
		chk("crc warn", bad && chk_en, warn);
	endtask

	task automatic man_wr(input logic [3:0] tg, input logic [5:0] a,
		input logic [15:0] d, input logic bad, input logic hit);
		int w;
		w = n_wr;
		host_u.send(1'b0, tg, a, d, bad, 8);
		chk("write count", hit, n_wr - w);
		if (hit) begin
			chk("write addr", a, wr_addr);
			chk("write data", d, wr_data);
		end
	endtask

	// Decodes the answer with the half length that the device chose
	task automatic man_rd(input logic [5:0] a, input int hb);
		logic [17:0] got;
		logic [15:0] e;
		int s, l, r;
		e = {a, 4'hA, a};
		if (a[0])
			e[15:8] = 8'h00;
		r = n_rd;
		host_u.send(1'b1, 4'h4, a, 16'h0, 1'b0, hb);
		tick(40 * (hb + 2));
		chk("read count", 1, n_rd - r);
		chk("read addr", a, rd_addr);
		s = 0;
		while (s < 900 && ans[s] !== 1'b1)
			s++;
		l = 1;
		while (l < 60 && ans[s+l] !== 1'b0)
			l++;
		chk("half length", 1, l >= hb && l <= hb + 3);
		for (int k = 0; k < 18; k++)
			got[17-k] = ~ans[s+2*k*l+l/2];
		chk("answer", {2'b00, e}, got);
		chk("released", 0, pwm_oe);
		chk("pwm data", 0, pwm_o);
	endtask

	initial begin
		tick(6);
		i_rstn = 1'b1;
		tick(6);
		chk("die id", 2'h2, die_id);
		chk_en = 1'b0;
		spi(16'hA5C3, 16'h1234, 1'b1);
		chk("rx word", 16'h1234, rx_word);
		chk_en = 1'b1;
		spi(16'h0F81, 16'hBEEF, 1'b1);
		chk("rx word kept", 16'h1234, rx_word);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		spi(16'h7E00, 16'hBEEF, 1'b0);
		chk("rx word", 16'hBEEF, rx_word);
		angle = 1'b0;
		tick(2);
		chk("angle out", 1, pwm_oe);
		man_wr(4'h4, 6'h12, 16'h5A5A, 1'b0, 1'b0);
		man_dis = 1'b1;
		host_u.send(1'b0, 4'h0, SPCM_ACC_ADDR, SPCM_ACC_DATA, 1'b0, 8);
		chk("mode disabled", 0, man_mode);
		man_dis = 1'b0;
		// Target misses this die, yet the access code is broadcast
		host_u.send(1'b0, 4'h1, SPCM_ACC_ADDR, SPCM_ACC_DATA, 1'b0, 8);
		chk("mode on", 1, man_mode);
		chk("angle stopped", 0, pwm_oe);
		man_wr(4'h4, 6'h12, 16'h5A5A, 1'b0, 1'b1);
		man_wr(4'hB, 6'h13, 16'h0F0F, 1'b0, 1'b0);
		// Outside PWM output mode the same missing target is taken
		pmode = 1'b0;
		man_wr(4'hB, 6'h13, 16'h0F0F, 1'b0, 1'b1);
		pmode = 1'b1;
		man_wr(4'h0, 6'h2B, 16'hC3A5, 1'b0, 1'b1);
		man_wr(4'h4, 6'h05, 16'h1111, 1'b1, 1'b0);
		man_rd(6'h24, 6);
		man_rd(6'h25, 12);
		host_u.send(1'b0, 4'h2, SPCM_ACC_ADDR, 16'h0000, 1'b0, 8);
		chk("mode off", 0, man_mode);
		chk("angle back", 1, pwm_oe);
		give_verdict();
	end
endmodule
`default_nettype wire
